/* File: design/sdrc_consts.svh */
// Offsets, field positions, reset values for the synthesizer config block
// Assumes inclusion by bare name from design files only
`ifndef SDRC_CONSTS_SVH
`define SDRC_CONSTS_SVH
`define SDRC_OFF_REFOUT     8'h3c
`define SDRC_OFF_FBDIV12    8'h3d
`define SDRC_OFF_FBDIV3     8'h3e
`define SDRC_OFF_OSCBIAS    8'h3f
`define SDRC_OFF_PREEMPH    8'h48
`define SDRC_RST_REFOUT     8'h01
`define SDRC_RST_FBDIV12    8'h00
`define SDRC_RST_FBDIV3     8'h20
`define SDRC_RST_OSCBIAS    8'h4f
`define SDRC_RST_PREEMPH    8'h00
`define SDRC_REFOUT_EN_BIT  0
`define SDRC_DIV2_MSB       3
`define SDRC_DIV2_LSB       2
`define SDRC_DIV1_MSB       1
`define SDRC_DIV1_LSB       0
`define SDRC_DIV3_MSB       5
`define SDRC_PE_MSB         3
`endif

/* File: design/sdrc_pkg.sv */
// Types shared by the synthesizer configuration block
// Assumes the constants header sits beside it
package sdrc_pkg;
    typedef enum logic [1:0] {
        SDRC_D2_BY1,
        SDRC_D2_BY2,
        SDRC_D2_BY4,
        SDRC_D2_RSVD
    } sdrc_div2_t;
    typedef struct packed {
        logic [7:0] refout;
        logic [7:0] fbdiv12;
        logic [7:0] fbdiv3;
        logic [7:0] oscbias;
        logic [7:0] preemph;
        logic [7:0] rdata;
        logic       refout_drive;
        logic [2:0] div1_ratio;
        logic [2:0] div2_ratio;
        logic [5:0] div3_ratio;
        logic [3:0] lane_pe;
    } sdrc_state_t;
    typedef struct packed {
        logic stage1;
        logic stage2;
    } sdrc_sync_t;
endpackage

/* File: design/sdrc_sync.sv */
// Two-stage synchroniser for a level arriving from a pin
// Assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module sdrc_sync (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_sync
);
    sdrc_pkg::sdrc_sync_t st;
    sdrc_pkg::sdrc_sync_t next_st;

    always_comb begin
        next_st.stage1 = i_async;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.stage2;
endmodule

/* File: design/sdrc_top.sv */
// Synthesizer divider, reference-output and lane pre-emphasis registers
// Assumes a decoded register write/read port on the configuration clock
//
// Summary of operation
// - Reference pins drive only with enable bit set and enable pin high
// - Reference enable bit resets to one so output runs unconfigured
// - Second divider field 3:2 selects divide by 1, 2, 4; 3 reserved
// - First divider field 1:0 selects divide by 5, 4, 3; 3 reserved
// - Third divider field 5:0 divides sampling clock by value, reset 32
// - Four-bit pre-emphasis level applies to all lanes together
`timescale 1ns/1ps
`include "sdrc_consts.svh"
module sdrc_top #(
    parameter int LANES = 8
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_synth_en_pin,
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    input  wire logic [7:0]           i_reg_addr,
    input  wire logic [7:0]           i_reg_wdata,
    output logic      [7:0]           o_reg_rdata,
    output logic                      o_reference_clock_out_en,
    output logic      [2:0]           o_div1_ratio,
    output logic      [2:0]           o_div2_ratio,
    output logic      [5:0]           o_div3_ratio,
    output logic      [6:0]           o_oscillator_bias_field,
    output logic      [LANES*4-1:0]   o_lane_preemphasis_level
);
    // ==========================================================
    // Parameter check
    if (LANES < 1 || LANES > 8) begin : g_bad_lanes
        $error("LANES out of range");
    end

    // ==========================================================
    // Decoding
    function automatic logic [2:0] div1_decode(input logic [1:0] c);
        unique case (c)
            2'h0: div1_decode = 3'h5;
            2'h1: div1_decode = 3'h4;
            2'h2: div1_decode = 3'h3;
            2'h3: div1_decode = 3'h0;
        endcase
    endfunction

    function automatic logic [2:0] div2_decode(input logic [1:0] c);
        unique case (sdrc_pkg::sdrc_div2_t'(c))
            sdrc_pkg::SDRC_D2_BY1:  div2_decode = 3'h1;
            sdrc_pkg::SDRC_D2_BY2:  div2_decode = 3'h2;
            sdrc_pkg::SDRC_D2_BY4:  div2_decode = 3'h4;
            sdrc_pkg::SDRC_D2_RSVD: div2_decode = 3'h0;
        endcase
    endfunction

    // ==========================================================
    // Pin synchroniser
    logic en_pin_s;
    sdrc_sync u_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async (i_synth_en_pin),
        .o_sync  (en_pin_s)
    );

    // ==========================================================
    // State
    sdrc_pkg::sdrc_state_t st;
    sdrc_pkg::sdrc_state_t next_st;

    always_comb begin
        next_st = st;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                `SDRC_OFF_REFOUT:  next_st.refout  = i_reg_wdata;
                `SDRC_OFF_FBDIV12: next_st.fbdiv12 = i_reg_wdata;
                `SDRC_OFF_FBDIV3:  next_st.fbdiv3  = i_reg_wdata;
                `SDRC_OFF_OSCBIAS: next_st.oscbias = i_reg_wdata;
                `SDRC_OFF_PREEMPH: next_st.preemph = i_reg_wdata;
                default: ;
            endcase
        end
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `SDRC_OFF_REFOUT:  next_st.rdata = st.refout;
                `SDRC_OFF_FBDIV12: next_st.rdata = st.fbdiv12;
                `SDRC_OFF_FBDIV3:  next_st.rdata = st.fbdiv3;
                `SDRC_OFF_OSCBIAS: next_st.rdata = st.oscbias;
                `SDRC_OFF_PREEMPH: next_st.rdata = st.preemph;
                default:           next_st.rdata = 8'h00;
            endcase
        end
        next_st.refout_drive = st.refout[`SDRC_REFOUT_EN_BIT]
                               & en_pin_s;
        next_st.div1_ratio = div1_decode(
            st.fbdiv12[`SDRC_DIV1_MSB:`SDRC_DIV1_LSB]);
        next_st.div2_ratio = div2_decode(
            st.fbdiv12[`SDRC_DIV2_MSB:`SDRC_DIV2_LSB]);
        next_st.div3_ratio = st.fbdiv3[`SDRC_DIV3_MSB:0];
        next_st.lane_pe = st.preemph[`SDRC_PE_MSB:0];
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st.refout       <= `SDRC_RST_REFOUT;
            st.fbdiv12      <= `SDRC_RST_FBDIV12;
            st.fbdiv3       <= `SDRC_RST_FBDIV3;
            st.oscbias      <= `SDRC_RST_OSCBIAS;
            st.preemph      <= `SDRC_RST_PREEMPH;
            st.rdata        <= 8'h00;
            st.refout_drive <= 1'b0;
            st.div1_ratio   <= 3'h5;
            st.div2_ratio   <= 3'h1;
            st.div3_ratio   <= 6'h20;
            st.lane_pe      <= 4'h0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign o_reg_rdata              = st.rdata;
    assign o_reference_clock_out_en = st.refout_drive;
    assign o_div1_ratio             = st.div1_ratio;
    assign o_div2_ratio             = st.div2_ratio;
    assign o_div3_ratio             = st.div3_ratio;
    assign o_oscillator_bias_field  = st.oscbias[6:0];

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign o_lane_preemphasis_level[g*4 +: 4] = st.lane_pe;
        end
    endgenerate

    // ==========================================================
    // Checks
    default clocking cb_chk @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    sequence wr_refout_s;
        i_reg_wr && i_reg_addr == `SDRC_OFF_REFOUT;
    endsequence

    sequence rd_refout_s;
        i_reg_rd && !i_reg_wr && i_reg_addr == `SDRC_OFF_REFOUT;
    endsequence

    sequence wr_fbdiv3_s;
        i_reg_wr && i_reg_addr == `SDRC_OFF_FBDIV3;
    endsequence

    sequence bus_quiet_s;
        !i_reg_wr;
    endsequence

    sequence div1_held_s(logic [1:0] c);
        (st.fbdiv12[`SDRC_DIV1_MSB:`SDRC_DIV1_LSB] == c) [*2];
    endsequence

    sequence div2_held_s(logic [1:0] c);
        (st.fbdiv12[`SDRC_DIV2_MSB:`SDRC_DIV2_LSB] == c) [*2];
    endsequence

    refout_gate_a: assert property (
        o_reference_clock_out_en ==
        ($past(st.refout[`SDRC_REFOUT_EN_BIT]) && $past(en_pin_s)))
        else $error("reference output gating wrong");
    refout_reset_a: assert property (
        $rose(i_rst_n) |-> st.refout == `SDRC_RST_REFOUT)
        else $error("refout reset value wrong");
    div2_by1_a: assert property (
        div2_held_s(2'h0) |-> o_div2_ratio == 3'h1)
        else $error("second divider by-1 map wrong");
    div2_by4_a: assert property (
        div2_held_s(2'h2) |-> o_div2_ratio == 3'h4)
        else $error("second divider by-4 map wrong");
    div2_rsvd_a: assert property (
        div2_held_s(2'h3) |-> o_div2_ratio == 3'h0)
        else $error("second divider reserved map wrong");
    div1_by5_a: assert property (
        div1_held_s(2'h0) |-> o_div1_ratio == 3'h5)
        else $error("first divider by-5 map wrong");
    div1_by3_a: assert property (
        div1_held_s(2'h2) |-> o_div1_ratio == 3'h3)
        else $error("first divider by-3 map wrong");
    div1_rsvd_a: assert property (
        div1_held_s(2'h3) |-> o_div1_ratio == 3'h0)
        else $error("first divider reserved map wrong");
    div3_follow_a: assert property (
        wr_fbdiv3_s ##1 bus_quiet_s
        |=> o_div3_ratio == $past(i_reg_wdata[5:0], 2))
        else $error("third divider not applied");
    div3_reset_a: assert property (
        $rose(i_rst_n) |-> o_div3_ratio == 6'h20
        && st.fbdiv3 == `SDRC_RST_FBDIV3)
        else $error("third divider reset value wrong");
    bias_follow_a: assert property (
        i_reg_wr && i_reg_addr == `SDRC_OFF_OSCBIAS
        |=> o_oscillator_bias_field == $past(i_reg_wdata[6:0]))
        else $error("oscillator bias not applied");
    pe_common_a: assert property (
        o_lane_preemphasis_level[3:0] == $past(st.preemph[`SDRC_PE_MSB:0])
        && o_lane_preemphasis_level[LANES*4-1 -: 4]
        == $past(st.preemph[`SDRC_PE_MSB:0]))
        else $error("lanes differ in pre-emphasis");
    refout_rdback_a: assert property (
        wr_refout_s ##1 rd_refout_s |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("readback mismatch");
    unmapped_rd_a: assert property (
        i_reg_rd && i_reg_addr == 8'h40 |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the synthesizer configuration registers
// Assumes design header, package and modules are compiled ahead of it
`timescale 1ns/1ps
module tb;
    localparam int       LANES = 8;
    localparam logic [2:0] D1_TAB [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
    localparam logic [2:0] D2_TAB [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    logic                i_mclk, i_rst_n, i_synth_en_pin;
    logic                i_reg_wr, i_reg_rd;
    logic [7:0]          i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic                o_reference_clock_out_en;
    logic [2:0]          o_div1_ratio, o_div2_ratio;
    logic [5:0]          o_div3_ratio;
    logic [6:0]          o_oscillator_bias_field;
    logic [LANES*4-1:0]  o_lane_preemphasis_level;
    logic [7:0]          exp_q [$];
    logic [7:0]          v;
    logic                rd_pend;
    int                  n_fail, n_tests;
    sdrc_top #(.LANES(LANES)) i_dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_synth_en_pin(i_synth_en_pin),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .o_reference_clock_out_en(o_reference_clock_out_en),
        .o_div1_ratio(o_div1_ratio), .o_div2_ratio(o_div2_ratio),
        .o_div3_ratio(o_div3_ratio),
        .o_oscillator_bias_field(o_oscillator_bias_field),
        .o_lane_preemphasis_level(o_lane_preemphasis_level));
    // ========================================
    // Tasks
    task automatic check(input string n, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        i_reg_wr = 1; i_reg_rd = 0; i_reg_addr = a; i_reg_wdata = d;
        @(posedge i_mclk); #2;
    endtask
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        i_reg_rd = 1; i_reg_wr = 0; i_reg_addr = a;
        @(posedge i_mclk); #2;
    endtask
    task automatic idle(input int n);
        i_reg_wr = 0; i_reg_rd = 0;
        repeat (n) begin @(posedge i_mclk); #2; end
    endtask
    task automatic reset_vals;
        rd(8'h3c, 8'h01); rd(8'h3d, 8'h00); rd(8'h3e, 8'h20);
        rd(8'h3f, 8'h4f); rd(8'h48, 8'h00); rd(8'h40, 8'h00);
        idle(2);
        check("div1", o_div1_ratio, 5);
        check("div2", o_div2_ratio, 1);
        check("div3", o_div3_ratio, 32);
        check("bias", o_oscillator_bias_field, 7'h4f);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ========================================
    // Clock, read monitor, watchdog
    initial begin i_mclk = 0; forever #12.5 i_mclk = ~i_mclk; end
    always @(negedge i_mclk) begin
        if (rd_pend) check("rdata", o_reg_rdata, exp_q.pop_front());
        rd_pend = i_reg_rd & i_rst_n;
    end
    initial begin repeat (100000) @(posedge i_mclk); n_fail++; print_verdict(); end
    // ========================================
    // Main sequence
    initial begin
        i_rst_n = 0; i_synth_en_pin = 0; i_reg_wr = 0; i_reg_rd = 0;
        i_reg_addr = 0; i_reg_wdata = 0; rd_pend = 0; n_fail = 0; n_tests = 0;
        void'($urandom(32'h82ec));
        idle(20); i_rst_n = 1; idle(1);
        reset_vals();
        check("refout_pin_low", o_reference_clock_out_en, 0);
        i_synth_en_pin = 1;
        idle(5);
        check("refout_default", o_reference_clock_out_en, 1);
        wr(8'h3c, 8'h00);
        rd(8'h3c, 8'h00);
        idle(3);
        check("refout_bit_off", o_reference_clock_out_en, 0);
        wr(8'h3c, 8'h01);
        idle(3);
        check("refout_bit_on", o_reference_clock_out_en, 1);
        i_synth_en_pin = 0;
        idle(5);
        check("refout_pin_off", o_reference_clock_out_en, 0);
        for (int i = 0; i < 16; i++) begin
            wr(8'h3d, 8'(i)); rd(8'h3d, 8'(i)); idle(3);
            check("div1", o_div1_ratio, D1_TAB[i%4]);
            check("div2", o_div2_ratio, D2_TAB[i/4]);
        end
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 8'h01 : (i == 1) ? 8'h3f : 8'($urandom_range(63, 1));
            wr(8'h3e, v); idle(3);
            check("div3", o_div3_ratio, v[5:0]);
            rd(8'h3e, v);
        end
        wr(8'h3f, 8'h4a); idle(3);
        check("bias", o_oscillator_bias_field, 7'h4a);
        for (int i = 0; i < 6; i++) begin
            v = {4'h0, 4'($urandom)};
            wr(8'h48, v); idle(3);
            check("lanes", o_lane_preemphasis_level, {LANES{v[3:0]}});
        end
        wr(8'h40, 8'h55); rd(8'h40, 8'h00); rd(8'h48, v);
        idle(2); i_rst_n = 0; idle(3); i_rst_n = 1; idle(1);
        reset_vals();
        check("lanes_rst", o_lane_preemphasis_level, 0);
        idle(3);
        check("reads_left", exp_q.size(), 0);
        print_verdict();
    end
endmodule
